/* File: ddt_timer.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - Activates spaced 7.5 ns x8, 10 ns x16.
// - Two cycles between column commands.
// - Auto-precharge write holds bank for WR plus tRP.
// - Write-to-read delay of 7.5 ns after burst.
// - 7.5 ns from read to precharge.
// - Hold clock enable three cycles per level.
// - Self refresh exit: refresh time plus 10 ns.
// - Self refresh exit: 200 cycles before read.
// - Precharge power-down exit: two cycles before command.
// - Active power-down exit: 2 or 7/8 minus AL.
// - Termination stable three cycles before power down.
// - Termination changes wait eight cycles after exit.
// - Two cycles after mode register set.
// - Clock runs on after clock enable drops.
// - Address bit 12 of mode set picks exit.
// - Read-to-precharge at least AL plus BL/2.
module ddt_timer
    import ddt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire ddt_cfg_s cfg,
    input wire logic req_valid,
    input wire ddt_req_s req,
    output logic req_ready,
    input wire logic odt_req,
    output ddt_pins_s pins,
    output ddt_state_e pwr_state
);
    function automatic ddt_cnt_t ld(input int n);
        return (n > 1) ? CW'(n - 1) : '0;
    endfunction

    ddt_state_e st_r, st_nxt;
    ddt_pins_s pins_r, pins_nxt;
    ddt_cnt_t rrd_r, rrd_nxt, ccd_r, ccd_nxt, wtr_r, wtr_nxt, mrd_r, mrd_nxt;
    ddt_cnt_t cke_r, cke_nxt, xsnr_r, xsnr_nxt, xsrd_r, xsrd_nxt, xp_r, xp_nxt;
    ddt_cnt_t xard_r, xard_nxt, axpd_r, axpd_nxt, odth_r, odth_nxt, dly_r, dly_nxt;
    logic slow_r, slow_nxt;
    logic [NBANK-1:0] open_v, act_ok, pre_ok;
    logic fire, base_ok, bank_open, all_closed;
    int wl, bl2, rd_pre, wr_pre;

    assign wl = int'(cfg.al) + int'(cfg.cl) - 1;
    assign bl2 = cfg.bl8 ? 4 : 2;
    assign rd_pre = int'(cfg.al) + ((bl2 > RTP_NCK) ? bl2 : RTP_NCK);
    assign wr_pre = wl + bl2 + int'(cfg.wr_nck);
    assign fire = req_valid && req_ready;
    assign bank_open = open_v[req.ba];
    assign all_closed = (open_v == '0);
    assign base_ok = (st_r == ST_ACT) && (mrd_r == '0) && (xp_r == '0);
    assign pins = pins_r;
    assign pwr_state = st_r;

    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        logic open_r, open_nxt;
        ddt_cnt_t act_r, act_nxt, pre_r, pre_nxt;
        logic hit;
        assign hit = fire && (req.ba == 3'(b));
        assign open_v[b] = open_r;
        assign act_ok[b] = (act_r == '0);
        assign pre_ok[b] = (pre_r == '0);
        always_comb begin
            open_nxt = open_r;
            act_nxt = (act_r != '0) ? act_r - 1'b1 : act_r;
            pre_nxt = (pre_r != '0) ? pre_r - 1'b1 : pre_r;
            if (hit && req.cmd == CMD_ACT) begin
                open_nxt = 1'b1;
            end else if (hit && req.cmd == CMD_RD) begin
                if (ld(rd_pre) > pre_nxt) begin
                    pre_nxt = ld(rd_pre);
                end
                if (req.addr[AP_BIT]) begin
                    open_nxt = 1'b0;
                    act_nxt = ld(rd_pre + int'(cfg.rp_nck));
                end
            end else if (hit && req.cmd == CMD_WR) begin
                pre_nxt = ld(wr_pre);
                if (req.addr[AP_BIT]) begin
                    open_nxt = 1'b0;
                    act_nxt = ld(wr_pre + int'(cfg.rp_nck));
                end
            end else if (fire && req.cmd == CMD_PRE && (hit || req.addr[AP_BIT])) begin
                open_nxt = 1'b0;
                act_nxt = ld(int'(cfg.rp_nck));
            end
        end
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                open_r <= 1'b0;
                act_r <= '0;
                pre_r <= '0;
            end else begin
                open_r <= open_nxt;
                act_r <= act_nxt;
                pre_r <= pre_nxt;
            end
        end
    end

    always_comb begin
        req_ready = 1'b0;
        case (req.cmd)
            CMD_ACT: req_ready = base_ok && (xsnr_r == '0) && (rrd_r == '0) && !bank_open
                && act_ok[req.ba];
            CMD_RD: req_ready = base_ok && (ccd_r == '0) && (wtr_r == '0) && bank_open
                && (xsrd_r == '0) && (xard_r == '0);
            CMD_WR: req_ready = base_ok && (xsnr_r == '0) && (ccd_r == '0) && bank_open;
            CMD_PRE: req_ready = base_ok && (xsnr_r == '0)
                && (req.addr[AP_BIT] ? (&pre_ok) : pre_ok[req.ba]);
            CMD_MRS: req_ready = base_ok && (xsnr_r == '0) && all_closed;
            CMD_SRE: req_ready = base_ok && (xsnr_r == '0) && all_closed && (cke_r == '0)
                && (odth_r == '0);
            CMD_PDE: req_ready = base_ok && (xsnr_r == '0) && (cke_r == '0)
                && (odth_r == '0);
            CMD_EXIT: req_ready = (st_r != ST_ACT) && (cke_r == '0) && pins_r.ck_run;
            default: req_ready = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        pins_nxt = pins_r;
        pins_nxt.cs_n = 1'b0;
        pins_nxt.ras_n = 1'b1;
        pins_nxt.cas_n = 1'b1;
        pins_nxt.we_n = 1'b1;
        slow_nxt = slow_r;
        rrd_nxt = (rrd_r != '0) ? rrd_r - 1'b1 : rrd_r;
        ccd_nxt = (ccd_r != '0) ? ccd_r - 1'b1 : ccd_r;
        wtr_nxt = (wtr_r != '0) ? wtr_r - 1'b1 : wtr_r;
        mrd_nxt = (mrd_r != '0) ? mrd_r - 1'b1 : mrd_r;
        cke_nxt = (cke_r != '0) ? cke_r - 1'b1 : cke_r;
        xsnr_nxt = (xsnr_r != '0) ? xsnr_r - 1'b1 : xsnr_r;
        xsrd_nxt = (xsrd_r != '0) ? xsrd_r - 1'b1 : xsrd_r;
        xp_nxt = (xp_r != '0) ? xp_r - 1'b1 : xp_r;
        xard_nxt = (xard_r != '0) ? xard_r - 1'b1 : xard_r;
        axpd_nxt = (axpd_r != '0) ? axpd_r - 1'b1 : axpd_r;
        odth_nxt = (odth_r != '0) ? odth_r - 1'b1 : odth_r;
        dly_nxt = (dly_r != '0) ? dly_r - 1'b1 : dly_r;
        // Termination follows its request only when the link is awake and settled.
        // A termination change never shares its edge with a power-down entry.
        if (st_r == ST_ACT && axpd_r == '0 && odt_req != pins_r.odt
            && !(fire && (req.cmd == CMD_PDE || req.cmd == CMD_SRE))) begin
            pins_nxt.odt = odt_req;
            odth_nxt = ld(ANPD_NCK);
        end
        // The clock is stopped only in self refresh, after the hold-on delay.
        if (st_r == ST_SR && dly_r == '0) begin
            pins_nxt.ck_run = 1'b0;
        end
        if (req_valid && req.cmd == CMD_EXIT && st_r == ST_SR) begin
            pins_nxt.ck_run = 1'b1;
        end
        if (fire) begin
            pins_nxt.ba = req.ba;
            pins_nxt.addr = req.addr;
            case (req.cmd)
                CMD_ACT: begin
                    pins_nxt.ras_n = 1'b0;
                    rrd_nxt = ld(cfg.x16 ? RRD_X16_NCK : RRD_X8_NCK);
                end
                CMD_RD: begin
                    pins_nxt.cas_n = 1'b0;
                    ccd_nxt = ld(CCD_NCK);
                end
                CMD_WR: begin
                    pins_nxt.cas_n = 1'b0;
                    pins_nxt.we_n = 1'b0;
                    ccd_nxt = ld(CCD_NCK);
                    wtr_nxt = ld(wl + bl2 + WTR_NCK);
                end
                CMD_PRE: begin
                    pins_nxt.ras_n = 1'b0;
                    pins_nxt.we_n = 1'b0;
                end
                CMD_MRS: begin
                    pins_nxt.ras_n = 1'b0;
                    pins_nxt.cas_n = 1'b0;
                    pins_nxt.we_n = 1'b0;
                    mrd_nxt = ld(MRD_NCK);
                    if (req.ba == 3'h0) begin
                        slow_nxt = req.addr[SLOW_EXIT_BIT];
                    end
                end
                CMD_SRE: begin
                    pins_nxt.ras_n = 1'b0;
                    pins_nxt.cas_n = 1'b0;
                    pins_nxt.cke = 1'b0;
                    cke_nxt = ld(CKE_NCK);
                    dly_nxt = ld(DELAY_NCK);
                    st_nxt = ST_SR;
                end
                CMD_PDE: begin
                    pins_nxt.cke = 1'b0;
                    cke_nxt = ld(CKE_NCK);
                    st_nxt = ST_PD;
                end
                CMD_EXIT: begin
                    pins_nxt.cke = 1'b1;
                    cke_nxt = ld(CKE_NCK);
                    axpd_nxt = ld(AXPD_NCK);
                    st_nxt = ST_ACT;
                    if (st_r == ST_SR) begin
                        xsnr_nxt = ld(int'(cfg.rfc_nck) + XSNR_ADD_NCK);
                        xsrd_nxt = ld(XSRD_NCK);
                    end else begin
                        xp_nxt = ld(XP_NCK);
                        if (!all_closed) begin
                            xard_nxt = ld(slow_r ? ((cfg.speed800 ? XARDS_800_NCK
                                : XARDS_667_NCK) - int'(cfg.al)) : XARD_NCK);
                        end
                    end
                end
                default: pins_nxt.cs_n = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_ACT;
            pins_r <= PINS_RST;
            slow_r <= 1'b0;
            rrd_r <= '0;
            ccd_r <= '0;
            wtr_r <= '0;
            mrd_r <= '0;
            cke_r <= '0;
            xsnr_r <= '0;
            xsrd_r <= '0;
            xp_r <= '0;
            xard_r <= '0;
            axpd_r <= '0;
            odth_r <= '0;
            dly_r <= '0;
        end else begin
            st_r <= st_nxt;
            pins_r <= pins_nxt;
            slow_r <= slow_nxt;
            rrd_r <= rrd_nxt;
            ccd_r <= ccd_nxt;
            wtr_r <= wtr_nxt;
            mrd_r <= mrd_nxt;
            cke_r <= cke_nxt;
            xsnr_r <= xsnr_nxt;
            xsrd_r <= xsrd_nxt;
            xp_r <= xp_nxt;
            xard_r <= xard_nxt;
            axpd_r <= axpd_nxt;
            odth_r <= odth_nxt;
            dly_r <= dly_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: ddt_pkg.sv */
`default_nettype none
package ddt_pkg;
    localparam int CK_PS = 10000;
    localparam int RRD_X8_PS = 7500;
    localparam int RRD_X16_PS = 10000;
    localparam int WTR_PS = 7500;
    localparam int RTP_PS = 7500;
    localparam int XSNR_ADD_PS = 10000;
    localparam int TIS_PS = 200;
    localparam int TIH_PS = 275;
    localparam int CCD_NCK = 2;
    localparam int CKE_NCK = 3;
    localparam int XSRD_NCK = 200;
    localparam int XP_NCK = 2;
    localparam int XARD_NCK = 2;
    localparam int XARDS_667_NCK = 7;
    localparam int XARDS_800_NCK = 8;
    localparam int ANPD_NCK = 3;
    localparam int AXPD_NCK = 8;
    localparam int MRD_NCK = 2;
    localparam int SLOW_EXIT_BIT = 12;
    localparam int AP_BIT = 10;
    localparam int NBANK = 8;
    localparam int CW = 9;

    // Least times round up to whole cycles, never below one.
    function automatic int ns2ck(input int ps);
        int c;
        c = (ps + CK_PS - 1) / CK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RRD_X8_NCK = ns2ck(RRD_X8_PS);
    localparam int RRD_X16_NCK = ns2ck(RRD_X16_PS);
    localparam int WTR_NCK = ns2ck(WTR_PS);
    localparam int RTP_NCK = ns2ck(RTP_PS);
    localparam int XSNR_ADD_NCK = ns2ck(XSNR_ADD_PS);
    localparam int DELAY_NCK = ns2ck(TIS_PS + CK_PS + TIH_PS);

    typedef logic [CW-1:0] ddt_cnt_t;

    typedef enum logic [3:0] {
        CMD_ACT = 4'h0, CMD_RD = 4'h1, CMD_WR = 4'h2, CMD_PRE = 4'h3,
        CMD_MRS = 4'h4, CMD_SRE = 4'h5, CMD_PDE = 4'h6, CMD_EXIT = 4'h7
    } ddt_cmd_e;

    typedef enum logic [2:0] {
        ST_ACT = 3'h1, ST_PD = 3'h2, ST_SR = 3'h4
    } ddt_state_e;

    typedef struct packed {
        ddt_cmd_e cmd;
        logic [2:0] ba;
        logic [14:0] addr;
    } ddt_req_s;

    typedef struct packed {
        logic x16;
        logic speed800;
        logic bl8;
        logic [2:0] al;
        logic [2:0] cl;
        logic [3:0] wr_nck;
        logic [3:0] rp_nck;
        logic [7:0] rfc_nck;
    } ddt_cfg_s;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic odt;
        logic ck_run;
        logic [2:0] ba;
        logic [14:0] addr;
    } ddt_pins_s;

    localparam ddt_pins_s PINS_RST = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
        we_n: 1'b1, odt: 1'b0, ck_run: 1'b1, ba: 3'h0, addr: 15'h0000};
endpackage
`default_nettype wire

/* File: ddt_timer_props.sv */
`timescale 1ns/1ns
`default_nettype none
module ddt_timer_props
    import ddt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire ddt_cfg_s cfg,
    input wire ddt_pins_s pins,
    input wire ddt_state_e pwr_state
);
    logic [3:0] cmd;
    logic is_cmd, is_col, odt_r, sr_r, sr_nxt, lp_r, lp_nxt;
    logic [7:0] up_r, up_nxt;
    logic [1:0] age_r, age_nxt;
    // Cycles with the clock enable high, and cycles the termination pin has stood still.
    always_comb begin
        cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
        is_cmd = !pins.cs_n && cmd[2:0] != 3'h7;
        is_col = cmd[3:1] == 3'h2;
        up_nxt = !pins.cke ? 8'h00 : up_r + {7'h00, up_r != 8'hFF};
        age_nxt = pins.odt != odt_r ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
        lp_nxt = lp_r || pwr_state != ST_ACT;
        sr_nxt = pwr_state == ST_SR || (sr_r && pwr_state != ST_PD);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            up_r <= 8'h00;
            age_r <= 2'h3;
            odt_r <= 1'b0;
            sr_r <= 1'b0;
            lp_r <= 1'b0;
        end else begin
            up_r <= up_nxt;
            age_r <= age_nxt;
            odt_r <= pins.odt;
            sr_r <= sr_nxt;
            lp_r <= lp_nxt;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    col_gap_a: assert property (is_col |=> !is_col) else $error("column gap");
    mrs_gap_a: assert property (is_cmd && cmd == 4'h0 |=> !is_cmd) else $error("mode gap");
    cke_hold_a: assert property ($changed(pins.cke) |=> $stable(pins.cke)[*2]) else $error("cke");
    pd_exit_a: assert property ($rose(pins.cke) && lp_r |-> !is_cmd ##1 !is_cmd) else $error("exit");
    sr_read_a: assert property (cmd == 4'h5 && sr_r |-> up_r >= 8'hC8) else $error("sr read");
    sr_cmd_a: assert property (is_cmd && cmd != 4'h5 && sr_r |-> up_r >= cfg.rfc_nck + 8'h01)
        else $error("sr cmd");
    odt_pd_a: assert property ($fell(pins.cke) |-> age_r >= 2'h2 && $stable(pins.odt))
        else $error("odt entry");
    odt_exit_a: assert property ($changed(pins.odt) && lp_r |-> pins.cke && up_r >= 8'h08)
        else $error("odt exit");
endmodule
bind ddt_timer ddt_timer_props u_ddt_timer_props (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
    .pins(pins), .pwr_state(pwr_state));
`default_nettype wire

/* File: ddt_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ddt_dev_model
    import ddt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire ddt_pins_s pins,
    output logic [7:0] viol,
    output logic dqs_diff,
    output logic [2:0] ocd_drv
);
    logic [NBANK-1:0] open_r;
    wire logic [3:0] cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    wire logic hit = open_r[pins.ba];
    // Bank misuse is counted; commands count only while the device clock runs.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            open_r <= '0;
            viol <= 8'h00;
            dqs_diff <= 1'b1;
            ocd_drv <= 3'h0;
        end else if (pins.ck_run) begin
            // An activate to an open bank, or a column command to a closed one.
            if ((cmd == 4'h3 && hit) || (cmd[3:1] == 3'h2 && !hit))
                viol <= viol + 8'h01;
            if (cmd[3:1] == 3'h0 && open_r != '0) viol <= viol + 8'h01;
            if (cmd == 4'h3) open_r[pins.ba] <= 1'b1;
            if (cmd == 4'h2 && pins.addr[AP_BIT]) open_r <= '0;
            else if (cmd == 4'h2 || (cmd[3:1] == 3'h2 && pins.addr[AP_BIT]))
                open_r[pins.ba] <= 1'b0;
            if (cmd == 4'h0 && pins.ba == 3'h1) begin
                dqs_diff <= !pins.addr[10];
                ocd_drv <= pins.addr[9:7];
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ddt_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic odt_req = 1'b0;
    logic req_ready, dqs_diff, slow;
    logic [2:0] b, ocd_drv;
    logic [7:0] viol;
    logic [31:0] seed = 32'h5793953C;
    ddt_cfg_s cfg = '0;
    ddt_req_s req = '0;
    ddt_pins_s pins;
    ddt_state_e pwr_state;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int n, bl2, wl;
    always #5 sys_clk = ~sys_clk;
    ddt_timer u_ddt_timer (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .odt_req(odt_req), .pins(pins), .pwr_state(pwr_state));
    ddt_dev_model u_ddt_dev_model (.sys_clk(sys_clk), .rst(rst), .pins(pins), .viol(viol),
        .dqs_diff(dqs_diff), .ocd_drv(ocd_drv));
    function automatic logic [31:0] nr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int f_xard();
        int e;
        e = (cfg.speed800 ? XARDS_800_NCK : XARDS_667_NCK) - int'(cfg.al);
        if (!slow) e = XARD_NCK;
        return e < XP_NCK ? XP_NCK : e;
    endfunction
    task automatic test_done();
        $display("err_total=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Called at a falling edge; returns at the falling edge after the take, request still up.
    task automatic issue(input ddt_cmd_e c, input logic [2:0] ba, input logic [14:0] a);
        n = 0;
        req_valid = 1'b1;
        req = '{cmd: c, ba: ba, addr: a};
        #1;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 300) err_total++;
        @(negedge sys_clk);
    endtask
    task automatic gap(input ddt_cmd_e c, input logic [2:0] ba, input logic [14:0] a, input int e);
        issue(c, ba, a);
        check(n + 1, e);
    endtask
    task automatic idle(input int k);
        req_valid = 1'b0;
        repeat (k) @(negedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (4) begin
            @(negedge sys_clk);
            rst = 1'b1;
            seed = nr(seed);
            cfg = '{x16: seed[0], speed800: seed[1], bl8: seed[2], al: 3'(seed[10:8] % 7),
                cl: 3'(3 + seed[13:11] % 5), wr_nck: 4'(2 + seed[17:14] % 5),
                rp_nck: 4'(2 + seed[21:18] % 4), rfc_nck: 8'(20 + seed[28:22])};
            odt_req = seed[5];
            slow = seed[3];
            b = seed[31:29];
            bl2 = cfg.bl8 ? 4 : 2;
            wl = cfg.al + cfg.cl - 1;
            repeat (6) @(negedge sys_clk);
            check(pins, PINS_RST);
            check(pwr_state, ST_ACT);
            rst = 1'b0;
            seed = nr(seed);
            issue(CMD_MRS, 3'h1, {4'h0, seed[10:7], 7'h00});
            issue(CMD_MRS, 3'h0, {2'h0, slow, 12'h000});
            check({dqs_diff, ocd_drv}, {!seed[10], seed[9:7]});
            gap(CMD_ACT, b, seed[14:0], MRD_NCK);
            gap(CMD_ACT, b ^ 3'h1, seed[29:15], RRD_X8_NCK);
            issue(CMD_WR, b, 15'h0000);
            gap(CMD_RD, b, 15'h0008, wl + bl2 + 1);
            gap(CMD_RD, b ^ 3'h1, 15'h0010, CCD_NCK);
            gap(CMD_PRE, b ^ 3'h1, 15'h0000, cfg.al + bl2);
            issue(CMD_WR, b, 15'h0400);
            gap(CMD_ACT, b, seed[14:0], wl + bl2 + cfg.wr_nck + cfg.rp_nck);
            issue(CMD_PDE, 3'h0, 15'h0000);
            check(pwr_state, ST_PD);
            gap(CMD_EXIT, 3'h0, 15'h0000, CKE_NCK);
            gap(CMD_RD, b, 15'h0000, f_xard());
            issue(CMD_PRE, 3'h0, 15'h0400);
            issue(CMD_SRE, 3'h0, 15'h0000);
            check(pwr_state, ST_SR);
            check(pins.ck_run, 1'b1);
            idle(1);
            check(pins.ck_run, 1'b1);
            idle(2);
            check(pins.ck_run, 1'b0);
            issue(CMD_EXIT, 3'h0, 15'h0000);
            odt_req = !odt_req;
            idle(7);
            check(pins.odt, !odt_req);
            idle(1);
            check(pins.odt, odt_req);
            gap(CMD_ACT, b, 15'h0000, cfg.rfc_nck + 1 - 8);
            gap(CMD_RD, b, 15'h0000, XSRD_NCK - cfg.rfc_nck - 1);
            idle(12);
            check(pins.odt, odt_req);
            check(viol, 8'h00);
        end
        test_done();
    end
endmodule
`default_nettype wire
